//--- rtl/octal_registered_bus_transceiver.sv
// octal registered bus transceiver with apb control registers
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "xcvr_regs.svh"

module octal_registered_bus_transceiver
  import xcvr_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // capture clock pins, sampled on pclk
  input wire logic a_store_clock,
  input wire logic b_store_clock,
  // A bus pins
  input wire logic [WIDTH-1:0] a_in,
  output logic [WIDTH-1:0] a_out,
  output logic [WIDTH-1:0] a_oe,
  // B bus pins
  input wire logic [WIDTH-1:0] b_in,
  output logic [WIDTH-1:0] b_out,
  output logic [WIDTH-1:0] b_oe
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // both stored values share one 32-bit word, so width is capped
  if (WIDTH < 1 || WIDTH > `MAX_WIDTH) begin : g_bad_width
    $error("octal_registered_bus_transceiver: WIDTH out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    apb_state_t apb_st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    ctrl_t ctrl;
    logic a_clk_prev;
    logic b_clk_prev;
    logic a_fresh;
    logic b_fresh;
    logic [`CNT_W-1:0] a_cnt;
    logic [`CNT_W-1:0] b_cnt;
    logic [WIDTH-1:0] a_out;
    logic [WIDTH-1:0] a_oe;
    logic [WIDTH-1:0] b_out;
    logic [WIDTH-1:0] b_oe;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic a_capture;
  logic b_capture;
  logic [WIDTH-1:0] a_side_register;
  logic [WIDTH-1:0] b_side_register;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  function automatic logic [WIDTH-1:0] fill(input logic bit_v);
    fill = {WIDTH{bit_v}};
  endfunction

  function automatic logic addr_known(input logic [`ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a == `OFF_CTRL) begin
      hit = 1'b1;
    end else if (a == `OFF_STORE) begin
      hit = 1'b1;
    end else if (a == `OFF_LIVE) begin
      hit = 1'b1;
    end else if (a == `OFF_STAT) begin
      hit = 1'b1;
    end
    addr_known = hit;
  endfunction

  // places two port-wide values into the A and B halves of a word
  function automatic logic [31:0] pack_pair(
    input logic [WIDTH-1:0] lo,
    input logic [WIDTH-1:0] hi
  );
    logic [31:0] w;
    w = `DATA_ZERO;
    w[WIDTH-1:0] = lo;
    w[`B_FIELD_LSB +: WIDTH] = hi;
    pack_pair = w;
  endfunction

  function automatic logic [31:0] read_word(
    input logic [`ADDR_W-1:0] a,
    input state_t s,
    input logic [WIDTH-1:0] aq,
    input logic [WIDTH-1:0] bq,
    input logic [WIDTH-1:0] ai,
    input logic [WIDTH-1:0] bi
  );
    logic [31:0] w;
    w = `DATA_ZERO;
    if (a == `OFF_CTRL) begin
      w[`CTRL_W-1:0] = s.ctrl;
    end else if (a == `OFF_STORE) begin
      w = pack_pair(aq, bq);
    end else if (a == `OFF_LIVE) begin
      w = pack_pair(ai, bi);
    end else if (a == `OFF_STAT) begin
      w[`STAT_A_FRESH_BIT] = s.a_fresh;
      w[`STAT_B_FRESH_BIT] = s.b_fresh;
      w[`STAT_A_CNT_LSB +: `CNT_W] = s.a_cnt;
      w[`STAT_B_CNT_LSB +: `CNT_W] = s.b_cnt;
    end
    read_word = w;
  endfunction

  // ----------------------------------------------------------------
  // capture edge detection
  // ----------------------------------------------------------------
  // pins are synchronous to pclk; the previous level resets high so
  // a pin already high at reset release is not taken as an edge.
  // only the pin's own history and ce are used: no select gates it
  assign a_capture = rise(a_store_clock, st_r.a_clk_prev) & ce;
  assign b_capture = rise(b_store_clock, st_r.b_clk_prev) & ce;

  // ----------------------------------------------------------------
  // storage registers
  // ----------------------------------------------------------------
  store_bank #(
    .WIDTH(WIDTH)
  ) u_store (
    .pclk(pclk),
    .ce(ce),
    .a_capture(a_capture),
    .b_capture(b_capture),
    .a_in(a_in),
    .b_in(b_in),
    .a_side_register(a_side_register),
    .b_side_register(b_side_register)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wr_take;
    logic drive_a;
    logic drive_b;
    wr_take = 1'b0;
    drive_a = 1'b0;
    drive_b = 1'b0;
    st_nxt = st_r;
    if (ce) begin
      // capture pin history
      st_nxt.a_clk_prev = a_store_clock;
      st_nxt.b_clk_prev = b_store_clock;

      // apb: one wait state, then the word is taken at the edge
      // where pready is seen high
      case (st_r.apb_st)
        APB_IDLE: begin
          if (psel && penable) begin
            st_nxt.apb_st = APB_DONE;
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = ~addr_known(paddr);
            if (!pwrite) begin
              st_nxt.prdata = read_word(paddr, st_r, a_side_register,
                                        b_side_register, a_in, b_in);
            end else begin
              st_nxt.prdata = `DATA_ZERO;
            end
          end
        end
        APB_DONE: begin
          st_nxt.apb_st = APB_IDLE;
          st_nxt.pready = 1'b0;
          st_nxt.pslverr = 1'b0;
          wr_take = psel & penable & pwrite;
        end
        default: begin
          st_nxt.apb_st = APB_IDLE;
          st_nxt.pready = 1'b0;
          st_nxt.pslverr = 1'b0;
        end
      endcase

      // register writes; read-only words ignore writes silently
      if (wr_take && paddr == `OFF_CTRL) begin
        st_nxt.ctrl = ctrl_t'(pwdata[`CTRL_W-1:0]);
      end

      // fresh flags: write one clears, a capture in the same cycle wins
      if (wr_take && paddr == `OFF_STAT) begin
        if (pwdata[`STAT_A_FRESH_BIT]) begin
          st_nxt.a_fresh = 1'b0;
        end
        if (pwdata[`STAT_B_FRESH_BIT]) begin
          st_nxt.b_fresh = 1'b0;
        end
      end
      if (a_capture) begin
        st_nxt.a_fresh = 1'b1;
        st_nxt.a_cnt = st_r.a_cnt + `CNT_ONE;
      end
      if (b_capture) begin
        st_nxt.b_fresh = 1'b1;
        st_nxt.b_cnt = st_r.b_cnt + `CNT_ONE;
      end

      // port drivers: only the port chosen by direction, and only
      // while drive allow is low; isolation leaves both undriven
      drive_b = ~st_r.ctrl.drive_allow_n & st_r.ctrl.dir;
      drive_a = ~st_r.ctrl.drive_allow_n & ~st_r.ctrl.dir;
      st_nxt.b_oe = fill(drive_b);
      st_nxt.a_oe = fill(drive_a);

      // data paths, straight copies; the stored source is read after
      // its own update lands, so a new capture shows one cycle later
      if (st_r.ctrl.b_out_source_sel) begin
        st_nxt.b_out = a_side_register;
      end else begin
        st_nxt.b_out = a_in;
      end
      if (st_r.ctrl.a_out_source_sel) begin
        st_nxt.a_out = b_side_register;
      end else begin
        st_nxt.a_out = b_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.apb_st <= APB_IDLE;
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.prdata <= `DATA_ZERO;
      st_r.ctrl <= ctrl_t'(`CTRL_RESET);
      st_r.a_clk_prev <= 1'b1;
      st_r.b_clk_prev <= 1'b1;
      st_r.a_fresh <= 1'b0;
      st_r.b_fresh <= 1'b0;
      st_r.a_cnt <= '0;
      st_r.b_cnt <= '0;
      st_r.a_out <= '0;
      st_r.a_oe <= '0;
      st_r.b_out <= '0;
      st_r.b_oe <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the far side must leave the driven bus alone; a_in and b_in of
  // a driven port only echo our own drive, which is harmless here
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign a_out = st_r.a_out;
  assign a_oe = st_r.a_oe;
  assign b_out = st_r.b_out;
  assign b_oe = st_r.b_oe;

endmodule // octal_registered_bus_transceiver

//--- rtl/xcvr_regs.svh
// register offsets, field positions and reset values of the transceiver
`ifndef XCVR_REGS_SVH
`define XCVR_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_STORE 8'h04
`define OFF_LIVE 8'h08
`define OFF_STAT 8'h0c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_W 4
`define CTRL_RESET 4'h1

// ----------------------------------------------------------------
// store, live and status register fields
// ----------------------------------------------------------------
`define B_FIELD_LSB 16
`define MAX_WIDTH 16
`define STAT_A_FRESH_BIT 0
`define STAT_B_FRESH_BIT 1
`define STAT_A_CNT_LSB 8
`define STAT_B_CNT_LSB 16
`define CNT_W 8
`define CNT_ONE 8'h01

// ----------------------------------------------------------------
// bus widths and constants
// ----------------------------------------------------------------
`define ADDR_W 8
`define DATA_ZERO 32'h0000_0000

`endif

//--- rtl/xcvr_pkg.sv
// types shared by the transceiver design files
package xcvr_pkg;

  // ----------------------------------------------------------------
  // control carrier, written by software over apb
  // ----------------------------------------------------------------
  typedef struct packed {
    logic a_out_source_sel;
    logic b_out_source_sel;
    logic dir;
    logic drive_allow_n;
  } ctrl_t;

  // ----------------------------------------------------------------
  // apb slave states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_DONE = 2'b01
  } apb_state_t;

endpackage

//--- rtl/store_bank.sv
// the two capture registers of the transceiver, deliberately without reset
`timescale 1ns/10ps
`include "xcvr_regs.svh"

module store_bank #(
  parameter int WIDTH = 8
) (
  // clock
  input wire logic pclk,
  input wire logic ce,
  // capture strobes, one pclk cycle each
  input wire logic a_capture,
  input wire logic b_capture,
  // live port data
  input wire logic [WIDTH-1:0] a_in,
  input wire logic [WIDTH-1:0] b_in,
  // stored values
  output logic [WIDTH-1:0] a_side_register,
  output logic [WIDTH-1:0] b_side_register
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] a_q;
    logic [WIDTH-1:0] b_q;
  } store_t;

  store_t st_r;
  store_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      // strobes are independent, so both may load in one cycle
      if (a_capture) begin
        st_nxt.a_q = a_in;
      end
      if (b_capture) begin
        st_nxt.b_q = b_in;
      end
    end
  end

  // no reset: contents are unknown until the first capture
  always_ff @(posedge pclk) begin
    st_r <= st_nxt;
  end

  assign a_side_register = st_r.a_q;
  assign b_side_register = st_r.b_q;

endmodule // store_bank

//--- testbench/xcvr_sva.sv
// port checker for the registered bus transceiver
`timescale 1ns/10ps
`include "xcvr_regs.svh"
module xcvr_sva
  import xcvr_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock, reset, apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // capture pins and buses
  input wire logic a_store_clock,
  input wire logic b_store_clock,
  input wire logic [WIDTH-1:0] a_in,
  input wire logic [WIDTH-1:0] a_out,
  input wire logic [WIDTH-1:0] a_oe,
  input wire logic [WIDTH-1:0] b_in,
  input wire logic [WIDTH-1:0] b_out,
  input wire logic [WIDTH-1:0] b_oe
);
  // ----------------------------------------------------------------
  // mirrors of control and stores, seen only through the ports
  // ----------------------------------------------------------------
  ctrl_t ctrl_m;
  logic [WIDTH-1:0] a_reg_m;
  logic [WIDTH-1:0] b_reg_m;
  logic a_clk_d;
  logic b_clk_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_m <= ctrl_t'(4'h1);
      a_clk_d <= 1'b1;
      b_clk_d <= 1'b1;
    end else if (ce) begin
      if (psel && penable && pready && pwrite && paddr == 8'h00)
        ctrl_m <= ctrl_t'(pwdata[3:0]);
      a_clk_d <= a_store_clock;
      b_clk_d <= b_store_clock;
    end
  end
  // no reset here: the real stores have none either
  always_ff @(posedge pclk) begin
    if (ce && a_store_clock && !a_clk_d)
      a_reg_m <= a_in;
    if (ce && b_store_clock && !b_clk_d)
      b_reg_m <= b_in;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_oe_b;
    $past(ce) |-> b_oe == {WIDTH{$past(!ctrl_m.drive_allow_n && ctrl_m.dir)}};
  endproperty
  a_oe_b: assert property (p_oe_b)
    else $error("b drive enable wrong");
  property p_oe_a;
    $past(ce) |-> a_oe == {WIDTH{$past(!ctrl_m.drive_allow_n && !ctrl_m.dir)}};
  endproperty
  a_oe_a: assert property (p_oe_a)
    else $error("a drive enable wrong");
  property p_live_b;
    b_oe[0] && $past(ce) && !$past(ctrl_m.b_out_source_sel)
      |-> b_out == $past(a_in);
  endproperty
  a_live_b: assert property (p_live_b)
    else $error("b live path wrong");
  property p_stored_b;
    b_oe[0] && $past(ctrl_m.b_out_source_sel) |-> b_out == $past(a_reg_m);
  endproperty
  a_stored_b: assert property (p_stored_b)
    else $error("b stored path wrong");
  property p_live_a;
    a_oe[0] && $past(ce) && !$past(ctrl_m.a_out_source_sel)
      |-> a_out == $past(b_in);
  endproperty
  a_live_a: assert property (p_live_a)
    else $error("a live path wrong");
  property p_stored_a;
    a_oe[0] && $past(ctrl_m.a_out_source_sel) |-> a_out == $past(b_reg_m);
  endproperty
  a_stored_a: assert property (p_stored_a)
    else $error("a stored path wrong");
  property p_single;
    a_oe == '0 || b_oe == '0;
  endproperty
  a_single: assert property (p_single)
    else $error("both buses driven");
  // drivers follow the control word of the previous cycle
  property p_iso;
    $past(ce) && $past(ctrl_m.drive_allow_n) |-> a_oe == '0 && b_oe == '0;
  endproperty
  a_iso: assert property (p_iso)
    else $error("isolation drives a bus");
  c_store_b: cover property (b_oe[0] && $past(ctrl_m.b_out_source_sel));
  c_store_a: cover property (a_oe[0] && $past(ctrl_m.a_out_source_sel));
  c_iso_cap: cover property (ctrl_m.drive_allow_n && a_store_clock && !a_clk_d);
endmodule // xcvr_sva

bind octal_registered_bus_transceiver xcvr_sva #(.WIDTH(WIDTH)) u_sva (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .a_store_clock(a_store_clock),
  .b_store_clock(b_store_clock), .a_in(a_in), .a_out(a_out), .a_oe(a_oe),
  .b_in(b_in), .b_out(b_out), .b_oe(b_oe));

//--- testbench/far_bus_model.sv
// far side of both data buses
`timescale 1ns/10ps
module far_bus_model #(
  parameter int WIDTH = 8
) (
  // device side of the buses
  input wire logic [WIDTH-1:0] a_out,
  input wire logic [WIDTH-1:0] a_oe,
  input wire logic [WIDTH-1:0] b_out,
  input wire logic [WIDTH-1:0] b_oe,
  // stimulus
  input wire logic drv_a,
  input wire logic drv_b,
  input wire logic [WIDTH-1:0] a_val,
  input wire logic [WIDTH-1:0] b_val,
  // resolved bus levels
  output logic [WIDTH-1:0] a_in,
  output logic [WIDTH-1:0] b_in
);
  // drives only bits the device leaves free; a released line shows the
  // inverse value so a stale level can never look like a match
  assign a_in = (a_oe & a_out) | (~a_oe & (drv_a ? a_val : ~a_val));
  assign b_in = (b_oe & b_out) | (~b_oe & (drv_b ? b_val : ~b_val));
endmodule // far_bus_model

//--- testbench/tb_octal_registered_bus_transceiver.sv
// self-checking bench for the registered bus transceiver
`timescale 1ns/10ps
module tb_octal_registered_bus_transceiver;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic a_store_clock = 1'b0;
  logic b_store_clock = 1'b0;
  logic drv_a = 1'b1;
  logic drv_b = 1'b1;
  logic [7:0] a_val = 8'h00;
  logic [7:0] b_val = 8'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [7:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  octal_registered_bus_transceiver #(.WIDTH(8)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .a_store_clock(a_store_clock), .b_store_clock(b_store_clock),
    .a_in(a_in), .a_out(a_out), .a_oe(a_oe),
    .b_in(b_in), .b_out(b_out), .b_oe(b_oe));
  far_bus_model #(.WIDTH(8)) far (
    .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .drv_a(drv_a), .drv_b(drv_b), .a_val(a_val), .b_val(b_val),
    .a_in(a_in), .b_in(b_in));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    forever #4 pclk = ~pclk;
  end
  // the whole run is somewhat over a hundred cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out;
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // control write, then let the one-cycle output latency pass
  task automatic ctrl(input logic [3:0] c);
    apb(1'b1, 8'h00, {28'h0, c});
    repeat (3) @(posedge pclk);
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] b);
    @(posedge pclk);
    a_val <= a;
    b_val <= b;
    repeat (3) @(posedge pclk);
  endtask
  // one sample high then low, the tightest legal capture spacing
  task automatic cap(input logic a, input logic b);
    @(posedge pclk);
    a_store_clock <= a;
    b_store_clock <= b;
    @(posedge pclk);
    a_store_clock <= 1'b0;
    b_store_clock <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0000_0001);
    put(8'h5a, 8'hc3);
    cap(1'b1, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h00c3_005a);
    check({24'h0, a_oe | b_oe}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, err}, 32'h1);
    drv_b <= 1'b0;
    ctrl(4'h2);
    put(8'h3c, 8'h00);
    check({16'h0, a_oe, b_oe}, 32'h0000_00ff);
    check({24'h0, b_out}, 32'h3c);
    put(8'h96, 8'h00);
    cap(1'b1, 1'b0);
    check({24'h0, b_out}, 32'h96);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h00c3_0096);
    ctrl(4'h6);
    check({24'h0, b_out}, 32'h96);
    put(8'h11, 8'h00);
    check({24'h0, b_out}, 32'h96);
    cap(1'b1, 1'b0);
    check({24'h0, b_out}, 32'h11);
    drv_a <= 1'b0;
    drv_b <= 1'b1;
    ctrl(4'h8);
    check({16'h0, a_oe, b_oe}, 32'h0000_ff00);
    check({24'h0, a_out}, 32'hc3);
    ctrl(4'h0);
    put(8'h00, 8'h77);
    check({24'h0, a_out}, 32'h77);
    cap(1'b0, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0077_0011);
    // enable low: a capture pulse and a new b level must be ignored
    ce <= 1'b0;
    put(8'h00, 8'h44);
    cap(1'b0, 1'b1);
    check({24'h0, a_out}, 32'h77);
    ce <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0077_0011);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0002_0303);
    apb(1'b1, 8'h0c, 32'h3);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0002_0300);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0044_0044);
    close_out();
  end
endmodule // tb_octal_registered_bus_transceiver
